// ---- pkg/smh_defs.vh ----
// Register map, field positions, codes and timing constants of the window/histogram block
`ifndef SMH_DEFS_VH
`define SMH_DEFS_VH
`define SMH_AW          8
`define SMH_OFS_CTRL    8'h00
`define SMH_OFS_STATUS  8'h04
`define SMH_OFS_PCNT    8'h08
`define SMH_OFS_PTIME   8'h0c
`define SMH_OFS_MCSBASE 8'h10
`define SMH_OFS_ACQT    8'h14
`define SMH_OFS_ROICNT  8'h18
`define SMH_OFS_HADDR   8'h1c
`define SMH_OFS_HDATA   8'h20
`define SMH_OFS_AUXSEL  8'h24
`define SMH_OFS_PWR     8'h28
`define SMH_OFS_LEGACY  8'h2c
`define SMH_OFS_PKT     8'h30
`define SMH_OFS_MCSCH   8'h34
`define SMH_SCA_PAGE    2'b01
`define SMH_CTRL_RUN    0
`define SMH_CTRL_MCS    1
`define SMH_CTRL_PCNT   2
`define SMH_CTRL_PTIME  3
`define SMH_CTRL_CLR    4
`define SMH_CTRL_NCH_L  8
`define SMH_CTRL_NCH_H  10
`define SMH_NCH_MAXCODE 3'd5
`define SMH_NCH_MIN     14'h0100
`define SMH_PWR_AUTO    0
`define SMH_PWR_LV      1
`define SMH_PWR_DET     2
`define SMH_PWR_TYPE_L  4
`define SMH_PWR_TYPE_H  5
`define SMH_DET_DRIFT   2'd2
`define SMH_EMU_NATIVE  2'd0
`define SMH_EMU_OLDEST  2'd1
`define SMH_EMU_OLDER   2'd2
`define SMH_PKT_NONE    2'd0
`define SMH_PKT_STATUS  2'd1
`define SMH_PKT_SPECT   2'd2
`define SMH_PKT_SCOPE   2'd3
`define SMH_AUX_NONE    4'h0
`define SMH_AUX_VALID   4'h1
`define SMH_AUX_ACCEPT  4'h2
`define SMH_AUX_ANYSCA  4'h3
`define SMH_AUX_RUN     4'h4
`define SMH_AUX_SCA0    4'h5
`define SMH_TICK_MS     100
`define SMH_CLK_KHZ     40000
`endif

// ---- hdl/smh_window.v ----
// One pulse-height window analyzer with inclusive limits
`default_nettype none
module smh_window #(
   parameter AMP_W = 13
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [AMP_W-1:0] lo_lim,
   input  wire [AMP_W-1:0] hi_lim,
   input  wire             accepted,
   input  wire [AMP_W-1:0] amp,
   output reg              hit_r
);
   // One-cycle logic pulse for an accepted peak inside the window
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= accepted && (amp >= lo_lim) && (amp <= hi_lim);
      end
   end
endmodule
`default_nettype wire

// ---- hdl/smh_core.v ----
// Window analyzers, shared histogram (amplitude or time scaler), packets, aux and supply sequencing
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`default_nettype none
`include "smh_defs.vh"
module smh_core #(
   parameter        NUM_SCA  = 8,
   parameter        AMP_W    = 13,
   parameter        CH_W     = 24,
   parameter        MAX_CH   = 8192,
   parameter [31:0] TICK_CYC = `SMH_TICK_MS * `SMH_CLK_KHZ
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire             psel,
   input  wire             penable,
   input  wire             pwrite,
   input  wire [31:0]      paddr,
   input  wire [31:0]      pwdata,
   output wire             pready,
   output reg  [31:0]      prdata,
   output wire             pslverr,
   input  wire             pulse_valid,
   input  wire [AMP_W-1:0] pulse_amp,
   input  wire             pileup_reject,
   input  wire             pulse_sel_ok,
   output wire [NUM_SCA-1:0] sca_out,
   output reg  [1:0]       aux_out_r,
   output reg              pkt_req_r,
   output reg  [1:0]       pkt_class_r,
   output reg  [13:0]      pkt_len_r,
   output reg              nvm_load_r,
   input  wire             nvm_done,
   input  wire             digital_ok,
   input  wire             cfg_done,
   input  wire             hw_bias_neg,
   output reg              lv_en_r,
   output reg              det_en_r
);
   integer i;
   integer j;
   integer k;
   wire [7:0] a = paddr[7:0];
   // Upper address bits must be zero, so aliases of the map are refused too
   wire       wr = psel && penable && pwrite && (paddr[31:8] == 24'h0);
   wire       setup = psel && !penable;
   wire       is_sca = (a[7:6] == `SMH_SCA_PAGE) && (a[1:0] == 2'b00) && (a[5:3] < NUM_SCA);

   // Control and configuration registers
   reg              run_r, mcs_r, pcnt_en_r, ptime_en_r, done_r;
   reg  [2:0]       nch_code_r;
   reg  [31:0]      pcnt_r, ptime_r, mcs_base_r;
   reg  [31:0]      acq_ticks_r, roi_cnt_r, tick_cnt_r, mcs_ticks_r;
   reg  [AMP_W-1:0] haddr_r, mcs_chan_r, clr_idx_r;
   reg  [CH_W-1:0]  mcs_sum_r;
   reg              clr_busy_r;
   reg  [3:0]       aux_sel_r [0:1];
   reg              pwr_auto_r, lv_cmd_r, det_cmd_r, pol_fault_r;
   reg  [1:0]       det_type_r, emu_r;
   reg              nvm_busy_r;
   reg  [AMP_W-1:0] lo_r [0:NUM_SCA-1];
   reg  [AMP_W-1:0] hi_r [0:NUM_SCA-1];
   reg  [CH_W-1:0]  hist_mem [0:MAX_CH-1];

   // Pulse selection: peak accepted only if not piled up and all criteria pass
   wire accepted = pulse_valid && !pileup_reject && pulse_sel_ok;
   wire roi_hit = sca_out[NUM_SCA-1];

   // One analyzer per window; the last also feeds preset count and scaler
   genvar g;
   generate
      for (g = 0; g < NUM_SCA; g = g + 1) begin : g_win
         smh_window #(
            .AMP_W   (AMP_W)
         ) u_win (
            .pclk    (pclk),
            .presetn (presetn),
            .lo_lim  (lo_r[g]),
            .hi_lim  (hi_r[g]),
            .accepted(accepted),
            .amp     (pulse_amp),
            .hit_r   (sca_out[g])
         );
      end
   endgenerate

   // Channel count is 256 shifted by the size code
   wire [13:0] nch = `SMH_NCH_MIN << nch_code_r;
   wire [13:0] last_ch = nch - 14'h0001;

   // Base tick of the acquisition clock: no preset finer than one tick
   wire tick = run_r && (tick_cnt_r == TICK_CYC - 32'h1);
   wire [31:0] ptime_eff = (ptime_r == 32'h0) ? 32'h1 : ptime_r;
   wire [31:0] base_eff = (mcs_base_r == 32'h0) ? 32'h1 : mcs_base_r;

   // Stop causes
   wire stop_pcnt = run_r && pcnt_en_r && roi_hit && (roi_cnt_r + 32'h1 >= pcnt_r);
   wire stop_ptime = tick && ptime_en_r && (acq_ticks_r + 32'h1 >= ptime_eff);
   wire mcs_end = tick && mcs_r && (mcs_ticks_r + 32'h1 >= base_eff);
   wire stop_mcs = mcs_end && ({1'b0, mcs_chan_r} >= last_ch);
   wire hw_stop = stop_pcnt || stop_ptime || stop_mcs;

   // Histogram writers are exclusive by mode
   wire mca_inc = run_r && !mcs_r && accepted && ({1'b0, pulse_amp} < nch);
   wire [CH_W-1:0] mca_old = hist_mem[pulse_amp];
   wire [CH_W-1:0] mca_new = (&mca_old) ? mca_old : mca_old + {{(CH_W-1){1'b0}}, 1'b1};
   wire [CH_W-1:0] mcs_total = mcs_sum_r + {{(CH_W-1){1'b0}}, roi_hit};

   wire ctrl_wr = wr && (a == `SMH_OFS_CTRL);
   wire start_wr = ctrl_wr && pwdata[`SMH_CTRL_RUN];

   // Run, mode and presets; mode and size only change while stopped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
         mcs_r <= 1'b0;
         pcnt_en_r <= 1'b0;
         ptime_en_r <= 1'b0;
         nch_code_r <= 3'd0;
         done_r <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            run_r <= pwdata[`SMH_CTRL_RUN] && !clr_busy_r;
            if (!run_r) begin
               mcs_r <= pwdata[`SMH_CTRL_MCS];
               pcnt_en_r <= pwdata[`SMH_CTRL_PCNT];
               ptime_en_r <= pwdata[`SMH_CTRL_PTIME];
               if (pwdata[`SMH_CTRL_NCH_H:`SMH_CTRL_NCH_L] > `SMH_NCH_MAXCODE) begin
                  nch_code_r <= `SMH_NCH_MAXCODE;
               end else begin
                  nch_code_r <= pwdata[`SMH_CTRL_NCH_H:`SMH_CTRL_NCH_L];
               end
            end
         end
         // Hardware stop beats a simultaneous software write
         if (hw_stop) begin
            run_r <= 1'b0;
         end
         // Done flag: a stop landing on the restart write is kept
         if (hw_stop) begin
            done_r <= 1'b1;
         end else if (start_wr) begin
            done_r <= 1'b0;
         end
      end
   end

   // Acquisition timers and region counter, restarted on each start
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_r <= 32'h0;
         acq_ticks_r <= 32'h0;
         roi_cnt_r <= 32'h0;
         mcs_ticks_r <= 32'h0;
         mcs_sum_r <= {CH_W{1'b0}};
         mcs_chan_r <= {{(AMP_W-1){1'b0}}, 1'b1};
      end else if (start_wr && !run_r) begin
         tick_cnt_r <= 32'h0;
         acq_ticks_r <= 32'h0;
         roi_cnt_r <= 32'h0;
         mcs_ticks_r <= 32'h0;
         mcs_sum_r <= {CH_W{1'b0}};
         mcs_chan_r <= {{(AMP_W-1){1'b0}}, 1'b1};
      end else if (run_r) begin
         tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
         if (tick) begin
            acq_ticks_r <= acq_ticks_r + 32'h1;
         end
         if (roi_hit) begin
            roi_cnt_r <= roi_cnt_r + 32'h1;
         end
         // Interval close: total goes to the current channel, then advance
         if (mcs_end) begin
            mcs_ticks_r <= 32'h0;
            mcs_sum_r <= {CH_W{1'b0}};
            mcs_chan_r <= mcs_chan_r + {{(AMP_W-1){1'b0}}, 1'b1};
         end else begin
            if (tick && mcs_r) begin
               mcs_ticks_r <= mcs_ticks_r + 32'h1;
            end
            if (mcs_r) begin
               mcs_sum_r <= mcs_total;
            end
         end
      end
   end

   // Histogram store; clear sweep takes one channel per cycle, requested while stopped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < MAX_CH; i = i + 1) begin
            hist_mem[i] <= {CH_W{1'b0}};
         end
         clr_busy_r <= 1'b0;
         clr_idx_r <= {AMP_W{1'b0}};
      end else begin
         if (clr_busy_r) begin
            hist_mem[clr_idx_r] <= {CH_W{1'b0}};
            clr_idx_r <= clr_idx_r + {{(AMP_W-1){1'b0}}, 1'b1};
            if ({1'b0, clr_idx_r} == last_ch) begin
               clr_busy_r <= 1'b0;
            end
         end else if (ctrl_wr && !run_r && pwdata[`SMH_CTRL_CLR]) begin
            clr_busy_r <= 1'b1;
            clr_idx_r <= {AMP_W{1'b0}};
         end else if (mcs_end && run_r) begin
            hist_mem[mcs_chan_r] <= mcs_total;
         end else if (mca_inc) begin
            hist_mem[pulse_amp] <= mca_new;
         end
      end
   end

   // Window limits, histogram pointer, aux selects, supply config, packets
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (j = 0; j < NUM_SCA; j = j + 1) begin
            lo_r[j] <= {AMP_W{1'b0}};
            hi_r[j] <= {AMP_W{1'b0}};
         end
         pcnt_r <= 32'h0;
         ptime_r <= 32'h0;
         mcs_base_r <= 32'h0;
         haddr_r <= {AMP_W{1'b0}};
         aux_sel_r[0] <= `SMH_AUX_NONE;
         aux_sel_r[1] <= `SMH_AUX_NONE;
         pwr_auto_r <= 1'b0;
         lv_cmd_r <= 1'b0;
         det_cmd_r <= 1'b0;
         det_type_r <= 2'd0;
         emu_r <= `SMH_EMU_NATIVE;
         nvm_load_r <= 1'b0;
         nvm_busy_r <= 1'b0;
         pkt_req_r <= 1'b0;
         pkt_class_r <= `SMH_PKT_NONE;
         pkt_len_r <= 14'h0;
      end else begin
         nvm_load_r <= 1'b0;
         pkt_req_r <= 1'b0;
         if (nvm_done) begin
            nvm_busy_r <= 1'b0;
         end
         if (wr && is_sca) begin
            if (a[2]) begin
               hi_r[a[5:3]] <= pwdata[AMP_W-1:0];
            end else begin
               lo_r[a[5:3]] <= pwdata[AMP_W-1:0];
            end
         end
         if (wr) begin
            case (a)
               `SMH_OFS_PCNT: pcnt_r <= pwdata;
               `SMH_OFS_PTIME: ptime_r <= pwdata;
               `SMH_OFS_MCSBASE: mcs_base_r <= pwdata;
               `SMH_OFS_HADDR: haddr_r <= pwdata[AMP_W-1:0];
               `SMH_OFS_AUXSEL: begin
                  aux_sel_r[0] <= pwdata[3:0];
                  aux_sel_r[1] <= pwdata[11:8];
               end
               `SMH_OFS_PWR: begin
                  pwr_auto_r <= pwdata[`SMH_PWR_AUTO];
                  lv_cmd_r <= pwdata[`SMH_PWR_LV];
                  det_cmd_r <= pwdata[`SMH_PWR_DET];
                  det_type_r <= pwdata[`SMH_PWR_TYPE_H:`SMH_PWR_TYPE_L];
               end
               `SMH_OFS_LEGACY: begin
                  emu_r <= pwdata[1:0];
                  if (pwdata[1:0] != `SMH_EMU_NATIVE) begin
                     nvm_load_r <= 1'b1;
                     nvm_busy_r <= 1'b1;
                  end
               end
               `SMH_OFS_PKT: begin
                  if (pwdata[1:0] != `SMH_PKT_NONE) begin
                     pkt_req_r <= 1'b1;
                     pkt_class_r <= pwdata[1:0];
                     // Spectral length is the channel count in either mode
                     pkt_len_r <= (pwdata[1:0] == `SMH_PKT_SPECT) ? nch : 14'h0;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Supply sequencing; drift detectors need negative bias
   wire boot_bias_neg = (det_type_r == `SMH_DET_DRIFT);
   wire pol_match = (boot_bias_neg == hw_bias_neg);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lv_en_r <= 1'b0;
         det_en_r <= 1'b0;
         pol_fault_r <= 1'b0;
      end else begin
         lv_en_r <= digital_ok && cfg_done && (pwr_auto_r || lv_cmd_r);
         det_en_r <= lv_en_r && det_cmd_r && pol_match;
         pol_fault_r <= lv_en_r && det_cmd_r && !pol_match;
      end
   end

   // Aux routing registered so the pins never glitch on a select change
   reg [NUM_SCA+4:0] aux_src;
   always @* begin
      aux_src = {sca_out, run_r, |sca_out, accepted, pulse_valid, 1'b0};
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_out_r <= 2'b00;
      end else begin
         for (k = 0; k < 2; k = k + 1) begin
            if (aux_sel_r[k] < `SMH_AUX_SCA0 + NUM_SCA) begin
               aux_out_r[k] <= aux_src[aux_sel_r[k]];
            end else begin
               aux_out_r[k] <= 1'b0;
            end
         end
      end
   end

   // Read mux; data is captured in the setup phase, so no wait state
   reg [31:0] rd_data;
   always @* begin
      rd_data = 32'h0;
      if (is_sca) begin
         rd_data[AMP_W-1:0] = a[2] ? hi_r[a[5:3]] : lo_r[a[5:3]];
      end else begin
         case (a)
            `SMH_OFS_CTRL: rd_data = {21'h0, nch_code_r, 3'h0, clr_busy_r, ptime_en_r, pcnt_en_r, mcs_r, run_r};
            `SMH_OFS_STATUS: rd_data = {24'h0, nvm_busy_r, pol_fault_r, det_en_r, lv_en_r, emu_r, done_r, run_r};
            `SMH_OFS_PCNT: rd_data = pcnt_r;
            `SMH_OFS_PTIME: rd_data = ptime_r;
            `SMH_OFS_MCSBASE: rd_data = mcs_base_r;
            `SMH_OFS_ACQT: rd_data = acq_ticks_r;
            `SMH_OFS_ROICNT: rd_data = roi_cnt_r;
            `SMH_OFS_HADDR: rd_data[AMP_W-1:0] = haddr_r;
            `SMH_OFS_HDATA: rd_data[CH_W-1:0] = hist_mem[haddr_r];
            `SMH_OFS_AUXSEL: rd_data = {20'h0, aux_sel_r[1], 4'h0, aux_sel_r[0]};
            `SMH_OFS_PWR: rd_data = {26'h0, det_type_r, 1'b0, det_cmd_r, lv_cmd_r, pwr_auto_r};
            `SMH_OFS_LEGACY: rd_data = {30'h0, emu_r};
            `SMH_OFS_PKT: rd_data = {2'h0, pkt_len_r, 14'h0, pkt_class_r};
            `SMH_OFS_MCSCH: rd_data[AMP_W-1:0] = mcs_chan_r;
            default: rd_data = 32'h0;
         endcase
      end
   end

   // Decode of mapped addresses for the error answer
   reg mapped;
   always @* begin
      mapped = is_sca;
      case (a)
         `SMH_OFS_CTRL, `SMH_OFS_STATUS, `SMH_OFS_PCNT, `SMH_OFS_PTIME,
         `SMH_OFS_MCSBASE, `SMH_OFS_ACQT, `SMH_OFS_ROICNT, `SMH_OFS_HADDR,
         `SMH_OFS_HDATA, `SMH_OFS_AUXSEL, `SMH_OFS_PWR, `SMH_OFS_LEGACY,
         `SMH_OFS_PKT, `SMH_OFS_MCSCH: mapped = 1'b1;
         default: mapped = is_sca;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (setup) begin
         prdata <= rd_data;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && (!mapped || (paddr[31:8] != 24'h0));
endmodule
`default_nettype wire

// ---- sim/smh_core_asserts.sv ----
// Port-level concurrent checks for the window and histogram block
`default_nettype none
`include "smh_defs.vh"
module smh_core_asserts #(
   parameter NUM_SCA = 8
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [31:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               pulse_valid,
   input wire logic               pileup_reject,
   input wire logic               pulse_sel_ok,
   input wire logic [NUM_SCA-1:0] sca_out,
   input wire logic               pkt_req_r,
   input wire logic [1:0]         pkt_class_r,
   input wire logic [13:0]        pkt_len_r,
   input wire logic               nvm_load_r,
   input wire logic               digital_ok,
   input wire logic               cfg_done,
   input wire logic               hw_bias_neg,
   input wire logic               lv_en_r,
   input wire logic               det_en_r
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ptype_r;
   logic       wr_acc;
   logic       mism;
   assign wr_acc = psel & penable & pwrite;
   // Shadow of the detector type, so the expected bias sense is known here
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptype_r <= 2'd0;
      end else if (wr_acc && paddr == {24'h0, `SMH_OFS_PWR}) begin
         ptype_r <= pwdata[5:4];
      end
   end
   assign mism = hw_bias_neg != (ptype_r == `SMH_DET_DRIFT);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_sca_accept: assert property (|sca_out |-> $past(pulse_valid && !pileup_reject && pulse_sel_ok))
      else $error("window pulse without accepted strobe");
   chk_lv_cause: assert property ($rose(lv_en_r) |-> $past(digital_ok && cfg_done))
      else $error("low supplies on without power and config");
   chk_lv_drop: assert property ((!digital_ok) [*2] |-> !lv_en_r)
      else $error("low supplies stay on without digital supply");
   chk_det_after_lv: assert property (det_en_r |-> $past(lv_en_r))
      else $error("detector supplies before low supplies");
   chk_det_polarity: assert property (mism [*3] |-> !det_en_r)
      else $error("detector supplies on with polarity mismatch");
   chk_pkt_issue: assert property (wr_acc && paddr == {24'h0, `SMH_OFS_PKT} && pwdata[31:2] == 30'h0
      && pwdata[1:0] != 2'd0 |-> ##[1:2] pkt_req_r)
      else $error("packet request missing");
   chk_pkt_class: assert property (pkt_req_r |-> pkt_class_r != `SMH_PKT_NONE)
      else $error("packet request without class");
   chk_pkt_len: assert property (pkt_req_r |-> ((pkt_class_r == `SMH_PKT_SPECT) ?
      pkt_len_r >= `SMH_NCH_MIN : pkt_len_r == 14'h0))
      else $error("packet length wrong for class");
   chk_nvm_load: assert property (wr_acc && paddr == {24'h0, `SMH_OFS_LEGACY} &&
      (pwdata == 32'h1 || pwdata == 32'h2) |-> ##[1:2] nvm_load_r)
      else $error("legacy config without nonvolatile load");
endmodule
bind smh_core smh_core_asserts #(.NUM_SCA(NUM_SCA)) i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pulse_valid, .pileup_reject, .pulse_sel_ok, .sca_out, .pkt_req_r, .pkt_class_r,
   .pkt_len_r, .nvm_load_r, .digital_ok, .cfg_done, .hw_bias_neg, .lv_en_r, .det_en_r);
`default_nettype wire

// ---- sim/smh_nvm_model.sv ----
// Nonvolatile parameter store answering load requests
`default_nettype none
module smh_nvm_model #(
   parameter DLY = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic nvm_load_r,
   output logic     nvm_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_r;
   // Fixed read time, then one done strobe; never answers unasked
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 0;
         nvm_done <= 1'b0;
      end else begin
         nvm_done <= (cnt_r == 1);
         if (nvm_load_r) begin
            cnt_r <= DLY;
         end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/sca_mcs_histogram_control_tb.sv ----
// Self-checking bench for the window, histogram and supply block
`default_nettype none
`include "smh_defs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module sca_mcs_histogram_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        pulse_valid;
   logic [12:0] pulse_amp;
   logic        pileup_reject;
   logic        pulse_sel_ok;
   logic [7:0]  sca_out;
   logic [1:0]  aux_out_r;
   logic        pkt_req_r;
   logic [1:0]  pkt_class_r;
   logic [13:0] pkt_len_r;
   logic        nvm_load_r;
   logic        nvm_done;
   logic        digital_ok;
   logic        cfg_done;
   logic        hw_bias_neg;
   logic        lv_en_r;
   logic        det_en_r;
   int          n_fail;
   int          check_count;
   int          cyc;
   logic [31:0] d;
   logic        e;
   // Short time base so scaler intervals last 20 cycles
   smh_core #(.TICK_CYC(32'd20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .pulse_valid, .pulse_amp, .pileup_reject, .pulse_sel_ok, .sca_out,
      .aux_out_r, .pkt_req_r, .pkt_class_r, .pkt_len_r, .nvm_load_r, .nvm_done, .digital_ok,
      .cfg_done, .hw_bias_neg, .lv_en_r, .det_en_r);
   smh_nvm_model i_nvm (.pclk, .presetn, .nvm_load_r, .nvm_done);
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0);
      `CHK(d, x)
   endtask
   task automatic hrd(input logic [31:0] a, input logic [31:0] x);
      xfer(1'b1, `SMH_OFS_HADDR, a);
      rdc(`SMH_OFS_HDATA, x);
   endtask
   // One peak strobe, window outputs looked at in the cycle after
   task automatic pls(input logic [12:0] a, input logic pu, input logic [7:0] x);
      @(posedge pclk);
      pulse_valid <= 1'b1;
      pulse_amp <= a;
      pileup_reject <= pu;
      @(posedge pclk);
      pulse_valid <= 1'b0;
      pileup_reject <= 1'b0;
      #1 `CHK(sca_out, x)
   endtask
   task automatic clr;
      xfer(1'b1, `SMH_OFS_CTRL, 32'h10);
      do xfer(1'b0, `SMH_OFS_CTRL, 32'h0); while (d[4] !== 1'b0);
   endtask
   // Hang guard, well above the scaler run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         finish_test;
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, pulse_valid, pileup_reject} = 6'h0;
      {paddr, pwdata, pulse_amp, digital_ok, cfg_done, hw_bias_neg} = 80'h0;
      pulse_sel_ok = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`SMH_OFS_STATUS, 32'h0);
      xfer(1'b0, 8'h3c, 32'h0);
      `CHK({e, d}, 33'h1_0000_0000)
      // Supply sequencing and polarity interlock
      xfer(1'b1, `SMH_OFS_PWR, 32'h5);
      repeat (3) @(posedge pclk);
      `CHK(lv_en_r, 1'b0)
      digital_ok <= 1'b1;
      cfg_done <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK({lv_en_r, det_en_r}, 2'b11)
      hw_bias_neg <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK(det_en_r, 1'b0)
      xfer(1'b0, `SMH_OFS_STATUS, 32'h0);
      `CHK(d[6], 1'b1)
      xfer(1'b1, `SMH_OFS_PWR, 32'h25);
      repeat (3) @(posedge pclk);
      `CHK(det_en_r, 1'b1)
      // Eight disjoint windows, edges and rejects of each
      for (int n = 0; n < 8; n++) begin
         xfer(1'b1, 8'h40 + 8'(8 * n), 32'(20 * n + 10));
         xfer(1'b1, 8'h44 + 8'(8 * n), 32'(20 * n + 15));
      end
      for (int n = 0; n < 8; n++) begin
         pls(13'(20 * n + 10), 1'b0, 8'h1 << n);
         pls(13'(20 * n + 15), 1'b0, 8'h1 << n);
         pls(13'(20 * n + 16), 1'b0, 8'h0);
         pls(13'(20 * n + 10), 1'b1, 8'h0);
      end
      @(posedge pclk) pulse_sel_ok <= 1'b0;
      pls(13'd150, 1'b0, 8'h0);
      @(posedge pclk) pulse_sel_ok <= 1'b1;
      xfer(1'b1, `SMH_OFS_AUXSEL, 32'h010c);
      pls(13'd150, 1'b0, 8'h80);
      `CHK(aux_out_r, 2'b10)
      @(posedge pclk);
      #1 `CHK(aux_out_r, 2'b01)
      // Amplitude histogram, 256 channels
      xfer(1'b1, `SMH_OFS_CTRL, 32'h1);
      repeat (3) pls(13'd150, 1'b0, 8'h80);
      pls(13'd300, 1'b0, 8'h0);
      xfer(1'b1, `SMH_OFS_CTRL, 32'h0);
      hrd(32'd150, 32'd3);
      hrd(32'd300, 32'd0);
      // Preset count in the last window
      clr;
      xfer(1'b1, `SMH_OFS_PCNT, 32'd3);
      xfer(1'b1, `SMH_OFS_CTRL, 32'h5);
      repeat (2) pls(13'd150, 1'b0, 8'h80);
      xfer(1'b0, `SMH_OFS_STATUS, 32'h0);
      `CHK(d[1:0], 2'b01)
      pls(13'd150, 1'b0, 8'h80);
      repeat (2) @(posedge pclk);
      xfer(1'b0, `SMH_OFS_STATUS, 32'h0);
      `CHK(d[1:0], 2'b10)
      rdc(`SMH_OFS_ROICNT, 32'd3);
      // Time scaler, one tick per interval, runs to the last channel
      clr;
      xfer(1'b1, `SMH_OFS_MCSBASE, 32'd1);
      xfer(1'b1, `SMH_OFS_CTRL, 32'h3);
      repeat (2) pls(13'd150, 1'b0, 8'h80);
      pls(13'd0, 1'b0, 8'h0);
      do xfer(1'b0, `SMH_OFS_STATUS, 32'h0); while (d[0] !== 1'b0);
      `CHK(d[1], 1'b1)
      hrd(32'd1, 32'd2);
      hrd(32'd2, 32'd0);
      hrd(32'd0, 32'd0);
      // Preset time of two base ticks; acquisition time counts whole ticks
      xfer(1'b1, `SMH_OFS_PTIME, 32'd2);
      xfer(1'b1, `SMH_OFS_CTRL, 32'h9);
      do xfer(1'b0, `SMH_OFS_STATUS, 32'h0); while (d[0] !== 1'b0);
      `CHK(d[1:0], 2'b10)
      rdc(`SMH_OFS_ACQT, 32'd2);
      // Every packet class, length follows channel count
      for (int c = 1; c < 4; c++) begin
         xfer(1'b1, `SMH_OFS_PKT, 32'(c));
         #1;
         for (int i = 0; i < 3 && pkt_req_r !== 1'b1; i++) @(posedge pclk) #1;
         `CHK({pkt_req_r, pkt_class_r}, {1'b1, 2'(c)})
         `CHK(pkt_len_r, (c == 2) ? 14'h0100 : 14'h0)
      end
      // Legacy modes load from the store, then back to native
      for (int c = 1; c < 4; c++) begin
         xfer(1'b1, `SMH_OFS_LEGACY, 32'(c % 3));
         repeat (8) @(posedge pclk);
         xfer(1'b0, `SMH_OFS_STATUS, 32'h0);
         `CHK({d[7], d[3:2]}, {1'b0, 2'(c % 3)})
      end
      finish_test;
   end
endmodule
`default_nettype wire
